// ---- rtl/sop_pkg.sv ----
/*
  Constants shared by the sum-of-products datapath and its output buffer.
  Assumes a single 125 MHz clock and a synchronous active-low reset.
*/
package sop_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int INSTR_W = 4;
  localparam int PSEL_W = 3;
  localparam int CTL_W = INSTR_W + 1;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_PTR_W = 1;
  localparam int BUF_CNT_W = 2;

  // ---------------------------------------------------------------
  // Pipeline select codes
  // ---------------------------------------------------------------
  localparam logic [PSEL_W-1:0] PSEL_FULL = 3'h0;
  localparam logic [PSEL_W-1:0] PSEL_FAST = 3'h2;

  // ---------------------------------------------------------------
  // Instruction word fields
  // ---------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int HOLD_BIT = 2;
  localparam int OUT_BIT = 3;
  localparam int FAST_BIT = 4;

  typedef enum logic [1:0] {
    OP_NOP = 2'h0,
    OP_MUL = 2'h1,
    OP_CHAIN = 2'h2,
    OP_CHAIN_HOLD = 2'h3
  } op_t;

  // ---------------------------------------------------------------
  // Reset values and buffer full count
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [CTL_W-1:0] CTL_RST = 5'h00;
  localparam logic [BUF_CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [BUF_CNT_W-1:0] CNT_FULL = 2'h2;

endpackage

// ---- rtl/sop_out_buffer.sv ----
/*
  Two-entry result buffer with valid and ready on both sides.
  Assumes the writer holds its word while in_ready_o is low.
*/
`timescale 1ns/100ps
module sop_out_buffer
  import sop_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [DATA_W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [DATA_W-1:0] mem [BUF_DEPTH];
  logic [BUF_PTR_W-1:0] wr_ptr;
  logic [BUF_PTR_W-1:0] rd_ptr;
  logic [BUF_CNT_W-1:0] count;
  logic [BUF_PTR_W-1:0] next_wr_ptr;
  logic [BUF_PTR_W-1:0] next_rd_ptr;
  logic [BUF_CNT_W-1:0] next_count;
  logic push;
  logic pop;

  assign in_ready_o = (count != CNT_FULL);
  assign out_valid_o = (count != CNT_RST);
  assign out_data_o = mem[rd_ptr];

  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= CNT_RST;
      mem[0] <= DATA_RST;
      mem[1] <= DATA_RST;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
      end
    end
  end

endmodule

// ---- rtl/sop_datapath.sv ----
/*
  Pipelined multiply-accumulate datapath: operand and instruction
  registers, multiplier pipe, product register, ALU pipe, sum register,
  hold register and a two-entry result buffer on the output bus.
  Assumes a sequencer that drives one instruction and operand pair per
  clock and holds them while ready_o is low.
*/
`timescale 1ns/100ps

// Behaviour
// - Everything updates on rising clock edge.
// - Capture operands and instruction, start executing.
// - Mode 000: product in pipe, then register.
// - Mode 000: first coordinate 11, then four.
// - Hold register keeps partial sum or product.
// - Mode 010: first sum six, then four.
// - Mode 010: operands, product, sum registers only.
module sop_datapath
  import sop_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Instruction and operands
  input wire logic issue_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [PSEL_W-1:0] pipeline_select_i,
  input wire logic [DATA_W-1:0] operand_bus_a_i,
  input wire logic [DATA_W-1:0] operand_bus_b_i,
  output logic ready_o,
  // Result bus
  output logic result_valid_o,
  output logic [DATA_W-1:0] result_o,
  input wire logic result_ready_i
);

  // ---------------------------------------------------------------
  // Stage registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] operand_a_register;
  logic [DATA_W-1:0] operand_b_register;
  logic [CTL_W-1:0] instr_reg;
  logic instr_v;
  logic [DATA_W-1:0] mul_pipe;
  logic [CTL_W-1:0] mul_ctl;
  logic mul_v;
  logic [DATA_W-1:0] prod_reg;
  logic [CTL_W-1:0] prod_ctl;
  logic prod_v;
  logic [DATA_W-1:0] alu_pipe;
  logic [CTL_W-1:0] alu_ctl;
  logic alu_v;
  logic [DATA_W-1:0] sum_reg;
  logic sum_out;
  logic [DATA_W-1:0] hold_reg;

  logic [DATA_W-1:0] next_operand_a_register;
  logic [DATA_W-1:0] next_operand_b_register;
  logic [CTL_W-1:0] next_instr_reg;
  logic next_instr_v;
  logic [DATA_W-1:0] next_mul_pipe;
  logic [CTL_W-1:0] next_mul_ctl;
  logic next_mul_v;
  logic [DATA_W-1:0] next_prod_reg;
  logic [CTL_W-1:0] next_prod_ctl;
  logic next_prod_v;
  logic [DATA_W-1:0] next_alu_pipe;
  logic [CTL_W-1:0] next_alu_ctl;
  logic next_alu_v;
  logic [DATA_W-1:0] next_sum_reg;
  logic next_sum_out;
  logic [DATA_W-1:0] next_hold_reg;

  logic stall;
  logic buf_ready;
  logic [2*DATA_W-1:0] full_prod;
  logic [DATA_W-1:0] addend;
  logic [DATA_W-1:0] alu_sum;
  logic [DATA_W-1:0] s_src;
  logic [CTL_W-1:0] s_src_ctl;
  logic s_src_v;
  op_t alu_op;
  op_t s_op;

  // A full buffer freezes every stage, so a stalled receiver loses no
  // result; the cost is that the sequencer must honour ready_o.
  assign stall = !buf_ready;
  assign ready_o = buf_ready;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    full_prod = operand_a_register * operand_b_register;
    alu_op = op_t'(prod_ctl[OP_LSB +: 2]);
    unique case (alu_op)
      OP_NOP: addend = DATA_RST;
      OP_MUL: addend = DATA_RST;
      OP_CHAIN: addend = sum_reg;
      OP_CHAIN_HOLD: addend = hold_reg;
    endcase
    alu_sum = prod_reg + addend;

    // Capture operands and instruction; execution starts here.
    next_operand_a_register = operand_bus_a_i;
    next_operand_b_register = operand_bus_b_i;
    next_instr_reg = {(pipeline_select_i == PSEL_FAST), instr_i};
    next_instr_v = issue_valid_i;

    // Mode 000 stops the product in the multiplier pipe first.
    next_mul_pipe = full_prod[DATA_W-1:0];
    next_mul_ctl = instr_reg;
    next_mul_v = instr_v && !instr_reg[FAST_BIT];
    if (instr_reg[FAST_BIT])
    begin
      next_prod_reg = full_prod[DATA_W-1:0];
      next_prod_ctl = instr_reg;
      next_prod_v = instr_v;
    end
    else
    begin
      next_prod_reg = mul_pipe;
      next_prod_ctl = mul_ctl;
      next_prod_v = mul_v;
    end

    next_alu_pipe = alu_sum;
    next_alu_ctl = prod_ctl;
    next_alu_v = prod_v && !prod_ctl[FAST_BIT];
    if (prod_ctl[FAST_BIT])
    begin
      s_src = alu_sum;
      s_src_ctl = prod_ctl;
      s_src_v = prod_v;
    end
    else
    begin
      s_src = alu_pipe;
      s_src_ctl = alu_ctl;
      s_src_v = alu_v;
    end
    s_op = op_t'(s_src_ctl[OP_LSB +: 2]);

    // The sum register only moves for a real add, so a running sum
    // survives idle slots between chained products.
    next_sum_reg = sum_reg;
    next_sum_out = 1'b0;
    if (s_src_v && (s_op != OP_NOP))
    begin
      next_sum_reg = s_src;
      next_sum_out = s_src_ctl[OUT_BIT];
    end

    next_hold_reg = hold_reg;
    if (prod_v && prod_ctl[HOLD_BIT])
    begin
      next_hold_reg = prod_reg;
    end
    else if (alu_v && alu_ctl[HOLD_BIT] && (alu_op == OP_NOP))
    begin
      next_hold_reg = alu_pipe;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      operand_a_register <= DATA_RST;
      operand_b_register <= DATA_RST;
      instr_reg <= CTL_RST;
      instr_v <= 1'b0;
      mul_pipe <= DATA_RST;
      mul_ctl <= CTL_RST;
      mul_v <= 1'b0;
      prod_reg <= DATA_RST;
      prod_ctl <= CTL_RST;
      prod_v <= 1'b0;
      alu_pipe <= DATA_RST;
      alu_ctl <= CTL_RST;
      alu_v <= 1'b0;
      sum_reg <= DATA_RST;
      sum_out <= 1'b0;
      hold_reg <= DATA_RST;
    end
    else if (!stall)
    begin
      operand_a_register <= next_operand_a_register;
      operand_b_register <= next_operand_b_register;
      instr_reg <= next_instr_reg;
      instr_v <= next_instr_v;
      mul_pipe <= next_mul_pipe;
      mul_ctl <= next_mul_ctl;
      mul_v <= next_mul_v;
      prod_reg <= next_prod_reg;
      prod_ctl <= next_prod_ctl;
      prod_v <= next_prod_v;
      alu_pipe <= next_alu_pipe;
      alu_ctl <= next_alu_ctl;
      alu_v <= next_alu_v;
      sum_reg <= next_sum_reg;
      sum_out <= next_sum_out;
      hold_reg <= next_hold_reg;
    end
  end

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  sop_out_buffer u_out_buffer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(sum_out),
    .in_data_i(sum_reg),
    .in_ready_o(buf_ready),
    .out_valid_o(result_valid_o),
    .out_data_o(result_o),
    .out_ready_i(result_ready_i)
  );

endmodule

// ---- verif/sop_datapath_checker.sv ----
/*
  Port checker for the sum-of-products datapath.
  Assumes it is bound to sop_datapath and shares its clock and reset.
*/
`timescale 1ns/100ps
module sop_datapath_checker
  import sop_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic issue_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [PSEL_W-1:0] pipeline_select_i,
  input wire logic [DATA_W-1:0] operand_bus_a_i,
  input wire logic [DATA_W-1:0] operand_bus_b_i,
  input wire logic ready_o,
  input wire logic result_valid_o,
  input wire logic [DATA_W-1:0] result_o,
  input wire logic result_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_reset_clears: assert property (disable iff (1'b0)
    !rstn_i |=> !result_valid_o && ready_o) else $error("Reset state wrong.");
  chk_head_holds: assert property (result_valid_o && !result_ready_i
    |=> result_valid_o && $stable(result_o)) else $error("Head word moved.");
  chk_full_latency: assert property (issue_valid_i && ready_o
    && instr_i[OUT_BIT] && instr_i[1:0] != 2'h0
    && pipeline_select_i == PSEL_FULL
    |-> ##[5:10] result_valid_o) else $error("Full mode result late.");
  chk_fast_latency: assert property (issue_valid_i && ready_o
    && instr_i[OUT_BIT] && instr_i[1:0] != 2'h0
    && pipeline_select_i == PSEL_FAST
    |-> ##[3:8] result_valid_o) else $error("Fast mode result late.");
  chk_stall_full: assert property (!ready_o |-> result_valid_o)
    else $error("Stall with empty buffer.");
  chk_pop_frees: assert property (!ready_o && result_ready_i
    |=> ready_o) else $error("Pop did not free a slot.");
  chk_stall_stays: assert property (!ready_o && !result_ready_i
    |=> !ready_o) else $error("Full buffer changed without a pop.");
endmodule

bind sop_datapath sop_datapath_checker chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .issue_valid_i(issue_valid_i), .instr_i(instr_i),
  .pipeline_select_i(pipeline_select_i), .operand_bus_a_i(operand_bus_a_i),
  .operand_bus_b_i(operand_bus_b_i), .ready_o(ready_o),
  .result_valid_o(result_valid_o), .result_o(result_o),
  .result_ready_i(result_ready_i));

// ---- verif/sop_sequencer.sv ----
/*
  Sequencer model driving one instruction and operand pair per call.
  Assumes a clock shared with the datapath and a stall on ready low.
*/
`timescale 1ns/100ps
module sop_sequencer
  import sop_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  output logic issue_valid_o,
  output logic [INSTR_W-1:0] instr_o,
  output logic [PSEL_W-1:0] psel_o,
  output logic [DATA_W-1:0] a_o,
  output logic [DATA_W-1:0] b_o
);
  initial
  begin
    issue_valid_o = 1'b0;
    instr_o = 4'h0;
    psel_o = PSEL_FULL;
    a_o = 32'h0;
    b_o = 32'h0;
  end

  // Holds the word through a stall, so no operand pair is lost.
  task automatic issue(input logic [INSTR_W-1:0] ins,
    input logic [PSEL_W-1:0] ps, input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b);
    @(negedge clk_i);
    issue_valid_o = 1'b1;
    instr_o = ins;
    psel_o = ps;
    a_o = a;
    b_o = b;
    @(posedge clk_i);
    while (!ready_i) @(posedge clk_i);
  endtask

  // Idle operand lines toggle, since the memory no longer drives them.
  task automatic gap(input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      issue_valid_o = 1'b0;
      a_o = ~a_o;
      b_o = ~b_o;
    end
  endtask
endmodule

// ---- verif/test_sop_datapath.sv ----
/*
  Self-checking bench of the sum-of-products datapath.
  Assumes the sequencer model drives the issue port.
*/
`timescale 1ns/100ps
module test_sop_datapath
  import sop_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic result_ready_i = 1'b1;
  logic issue_valid_i;
  logic [INSTR_W-1:0] instr_i;
  logic [PSEL_W-1:0] pipeline_select_i;
  logic [DATA_W-1:0] operand_bus_a_i;
  logic [DATA_W-1:0] operand_bus_b_i;
  logic ready_o;
  logic result_valid_o;
  logic [DATA_W-1:0] result_o;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] acc;
  logic [31:0] rng = 32'h31ed;
  logic [31:0] r;
  logic [1:0] drain = 2'h0;
  logic saw_stall = 1'b0;
  logic [3:0] prog[3] = '{4'h1, 4'h0, 4'ha};
  logic [3:0] prog2[7] = '{4'h1, 4'h0, 4'h6, 4'h0, 4'h1, 4'h0, 4'hb};
  int pops = 0;
  int first_pop = 0;
  int second_pop = 0;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  sop_sequencer seq (.clk_i(clk_i), .ready_i(ready_o),
    .issue_valid_o(issue_valid_i), .instr_o(instr_i),
    .psel_o(pipeline_select_i), .a_o(operand_bus_a_i),
    .b_o(operand_bus_b_i));
  sop_datapath uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i),
    .pipeline_select_i(pipeline_select_i), .operand_bus_a_i(operand_bus_a_i),
    .operand_bus_b_i(operand_bus_b_i), .ready_o(ready_o),
    .result_valid_o(result_valid_o), .result_o(result_o),
    .result_ready_i(result_ready_i));

  initial forever #4 clk_i = ~clk_i;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen,
    input logic [DATA_W-1:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Drain side: always ready, random, or stalled.
  always @(negedge clk_i)
  begin
    r = xs();
    result_ready_i <= (drain == 2'h0) | (drain == 2'h1 & r[0]);
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (rstn_i === 1'b1 && ready_o === 1'b0)
      saw_stall = 1'b1;
    if (rstn_i === 1'b1 && result_valid_o === 1'b1 && result_ready_i)
    begin
      pops++;
      if (pops == 1)
        first_pop = cycles;
      if (pops == 2)
        second_pop = cycles;
      check({31'h0, exp_q.size() > 0}, 32'h1);
      if (exp_q.size() > 0)
        check(result_o, exp_q.pop_front());
    end
    if (cycles == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    // Fast mode, four-term sums issued without gaps.
    repeat (2)
    begin
      acc = 32'h0;
      for (int k = 0; k < 4; k++)
      begin
        a = xs();
        b = xs();
        acc += a * b;
        seq.issue(k == 0 ? 4'h1 : (k == 3 ? 4'ha : 4'h2), PSEL_FAST, a, b);
      end
      exp_q.push_back(acc);
    end
    seq.gap(8);
    // Full mode: held product as the addend.
    a = xs();
    b = xs();
    acc = a * b;
    seq.issue(4'h5, PSEL_FULL, a, b);
    a = xs();
    b = xs();
    acc += a * b;
    exp_q.push_back(acc);
    seq.issue(4'hb, PSEL_FULL, a, b);
    seq.gap(8);
    // Full mode: chain reads the sum two issues back.
    acc = 32'h0;
    for (int k = 0; k < 3; k++)
    begin
      a = xs();
      b = xs();
      if (k != 1)
        acc += a * b;
      if (k == 2)
        exp_q.push_back(acc);
      seq.issue(prog[k], PSEL_FULL, a, b);
    end
    seq.gap(8);
    // Full mode: a partial sum parked in the hold register, S overwritten.
    acc = 32'h0;
    for (int k = 0; k < 7; k++)
    begin
      a = xs();
      b = xs();
      if (k == 0 || k == 2 || k == 6)
        acc += a * b;
      seq.issue(prog2[k], PSEL_FULL, a, b);
    end
    exp_q.push_back(acc);
    seq.gap(8);
    // Stalled drain fills the buffer; the issue port must wait.
    drain = 2'h2;
    fork
      begin
        repeat (20) @(posedge clk_i);
        drain = 2'h1;
      end
    join_none
    repeat (12)
    begin
      a = xs();
      b = xs();
      exp_q.push_back(a * b);
      seq.issue(4'h9, PSEL_FAST, a, b);
    end
    seq.gap(1);
    drain = 2'h0;
    for (int w = 0; w < 100 && exp_q.size() > 0; w++)
      @(posedge clk_i);
    check(exp_q.size(), 32'h0);
    check({31'h0, saw_stall}, 32'h1);
    check(second_pop - first_pop, 32'h4);
    stop_test();
  end
endmodule
